// file: core/sre_bypass.v
/*
 * One bypass-disable bit slot with read-as-one when the bypass is absent.
 * Assumes writes are already qualified by the alias decision in the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module sre_bypass #(
    parameter HAS_BYPASS = 1
) (
    input  wire clk,
    input  wire rst,
    input  wire wr_en,
    input  wire wr_bit,
    output wire rd_bit
);
    reg bit_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_q <= 1'b0;
        end else if (wr_en && (HAS_BYPASS != 0)) begin
            bit_q <= wr_bit;
        end
    end

    assign rd_bit = (HAS_BYPASS != 0) ? bit_q : 1'b1;
endmodule

`default_nettype wire

// file: core/sre_cell.v
/*
 * One interface-enable storage cell with read-as-zero gating and a fixed
 * read-as-one option.
 * Assumes the caller supplies the gate and write strobe in the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module sre_cell #(
    parameter FIXED_ONE = 0
) (
    input  wire clk,
    input  wire rst,
    input  wire gate_open,
    input  wire wr_en,
    input  wire wr_bit,
    output wire rd_bit
);
    reg bit_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_q <= 1'b0;
        end else if (wr_en && gate_open) begin
            bit_q <= wr_bit;
        end
    end

    // A closed gate reads zero; on reopening the stored value is kept, which
    // is one legal choice for the unknown value.
    assign rd_bit = (FIXED_ONE != 0) ? 1'b1 : (gate_open & bit_q);
endmodule

`default_nettype wire

// file: core/sre_defs.vh
/*
 * Constants for the system-register-interface enable bank: field positions,
 * access encoding, syndrome class and outcome codes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SRE_DEFS_VH
`define SRE_DEFS_VH

// ============================================================
// Field positions
`define SRE_BIT_IFACE_EN      0
`define SRE_BIT_FIQ_BYP_DIS   1
`define SRE_BIT_IRQ_BYP_DIS   2
`define SRE_BIT_TRAP_EN       3
`define SRE_REG_W             64

// ============================================================
// Access encoding of the level-1 register
`define SRE_ENC_OP0           2'h3
`define SRE_ENC_OP1           3'h0
`define SRE_ENC_CRN           4'hC
`define SRE_ENC_CRM           4'hC
`define SRE_ENC_OP2           3'h5
// Level-2 register encoding: op1 0b100, CRm 0b1001.
`define SRE_ENC2_OP1          3'h4
`define SRE_ENC2_CRM          4'h9

// ============================================================
// Exception levels and outcomes
`define SRE_EL0               2'h0
`define SRE_EL1               2'h1
`define SRE_EL2               2'h2
`define SRE_EL3               2'h3
`define SRE_SYNDROME_CLASS    6'h18
`define SRE_RES_OK            3'h0
`define SRE_RES_UNDEF         3'h1
`define SRE_RES_TRAP_EL1      3'h2
`define SRE_RES_TRAP_EL2      3'h3
`define SRE_RES_TRAP_EL3      3'h4
`define SRE_RES_NOHIT         3'h5

`endif

// file: core/sre_enable_bank.v
/*
 * System-register-interface enable bank for levels 1 and 2.
 * Assumes a processor core presenting one access per cycle with its level,
 * encoding and security state; level-3 bits arrive as inputs from outside.
 */
// What this block does
// R1 - Level-1 register is 64 bits; banked Secure/Non-secure when level 3 exists.
// R2 - Bit 2 is IRQ bypass disable; one disables bypass.
// R3 - Bit 1 is FIQ bypass disable; one disables bypass.
// R4 - Level 3, security-disable 0: level-1 bypass bits read level-3 bits only.
// R5 - Level 3, security-disable 1, no level 2: read/write level-3 bits.
// R6 - No level 3, level 2 present: read level-2 bits, writes ignored.
// R7 - Security-disable 1 with level 2: read-only mirror of level-2 bits.
// R8 - Missing IRQ or FIQ bypass: bit reads one, writes ignored.
// R9 - Warm reset clears bypass bits and interface enable bits.
// R10 - Bit 0 zero: other interface registers trap to level 1.
// R11 - Bit 0 one enables the interface for the copy's security state.
// R12 - Level-3 enable zero: Secure copy reads zero, ignores writes.
// R13 - Level-2 or level-3 enable zero: Non-secure copy reads zero.
// R14 - Only-sysreg or realm extension: interface enable reads one.
// R15 - Fixed-one copies only when higher-level enables are fixed too; the Non-secure copy here needs only the level-2 enable fixed, not level 3.
// R16 - Level 0 undefined; level-1 trap to level 2 with class 0x18.
// R17 - Secure-state select 0 picks Secure copy, else Non-secure.
// R18 - Level-1 register encoding op0 3, op1 0, CRn 12, CRm 12, op2 5.
// R19 - Level-2 register 64 bits, bits 63..4 zero, inert without level 2.
// R20 - Level-2 bit 3 zero traps level-1 accesses to level 2.
// R21 - Level-2 enable zero makes trap bit act as one except on read.
// R22 - With level 3, level-2 bypass bits mirror level-3 bits.
`timescale 1ns/1ps
`default_nettype none
`include "sre_defs.vh"

module sre_enable_bank #(
    parameter HAVE_EL3      = 1,
    parameter HAVE_EL2      = 1,
    parameter HAS_IRQ_BYP   = 1,
    parameter HAS_FIQ_BYP   = 1,
    parameter SYSREG_ONLY   = 0,
    parameter REALM_EXT     = 0,
    parameter FIX_EL2_ONE   = 0,
    parameter FIX_EL3_ONE   = 0,
    parameter FIX_NS_ONE    = 0,
    parameter FIX_S_ONE     = 0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        acc_valid,
    input  wire        acc_write,
    input  wire [1:0]  acc_el,
    input  wire [1:0]  acc_op0,
    input  wire [2:0]  acc_op1,
    input  wire [3:0]  acc_crn,
    input  wire [3:0]  acc_crm,
    input  wire [2:0]  acc_op2,
    input  wire [63:0] acc_wdata,
    input  wire        secure_state_select,
    input  wire        distributor_security_disable,
    input  wire        el2_enabled,
    input  wire        lvl3_iface_en,
    input  wire        lvl3_irq_bypass_disable,
    input  wire        lvl3_fiq_bypass_disable,
    output reg         lvl3_bypass_wr,
    output reg  [1:0]  lvl3_bypass_wdata,
    output reg         acc_done,
    output reg  [2:0]  acc_result,
    output reg  [5:0]  acc_syndrome,
    output reg  [63:0] acc_rdata,
    output reg         iface_en_current,
    output reg         other_sysreg_trap_lvl1,
    output reg         irq_bypass_disable,
    output reg         fiq_bypass_disable
);
    localparam EFF_FIX_NS = (FIX_NS_ONE != 0) && (FIX_EL2_ONE != 0);
    localparam EFF_FIX_S  = (FIX_S_ONE != 0) && (FIX_EL2_ONE != 0) && (FIX_EL3_ONE != 0);
    localparam RAO_ALL    = (SYSREG_ONLY != 0) || (REALM_EXT != 0);

    // ============================================================
    // Helpers
    // Both registers share op0, CRn and op2; only op1 and CRm tell them apart.
    function enc_match;
        input [1:0] op0;
        input [2:0] op1;
        input [3:0] crn;
        input [3:0] crm;
        input [2:0] op2;
        input [2:0] want_op1;
        input [3:0] want_crm;
        begin
            enc_match = (op0 == `SRE_ENC_OP0) && (op1 == want_op1) && (crn == `SRE_ENC_CRN) &&
                        (crm == want_crm) && (op2 == `SRE_ENC_OP2);
        end
    endfunction

    function is_trap;
        input [2:0] res;
        begin
            is_trap = (res == `SRE_RES_TRAP_EL1) || (res == `SRE_RES_TRAP_EL2) ||
                      (res == `SRE_RES_TRAP_EL3);
        end
    endfunction

    // ============================================================
    // Access decode
    wire hit1 = acc_valid &&
                enc_match(acc_op0, acc_op1, acc_crn, acc_crm, acc_op2, `SRE_ENC_OP1, `SRE_ENC_CRM); // R18
    wire hit2 = acc_valid &&
                enc_match(acc_op0, acc_op1, acc_crn, acc_crm, acc_op2, `SRE_ENC2_OP1, `SRE_ENC2_CRM);
    wire el2_live = (HAVE_EL2 != 0) && el2_enabled; // R19
    wire lvl3_gate = (HAVE_EL3 == 0) || lvl3_iface_en;

    // ============================================================
    // Level-2 register storage
    reg  trap_en_q;
    reg  iface2_q;
    wire iface2_rd = (FIX_EL2_ONE != 0 || RAO_ALL) ? 1'b1 : (iface2_q & lvl3_gate);
    // Trap enable acts as one while the level-2 interface is off.
    wire trap_en_eff = trap_en_q | ~iface2_rd; // R21

    // ============================================================
    // Security-state copy selection
    wire sel_secure = (HAVE_EL3 != 0) && !secure_state_select; // R17
    wire gate_s  = lvl3_gate; // R12
    wire gate_ns = lvl3_gate && ((HAVE_EL2 == 0) || iface2_rd); // R13

    // ============================================================
    // Outcome of a level-1 or level-2 register access
    reg [2:0] res1;
    always @* begin
        res1 = `SRE_RES_OK;
        if (acc_el == `SRE_EL0) begin
            res1 = `SRE_RES_UNDEF; // R16
        end else if (acc_el == `SRE_EL1 && el2_live && !trap_en_eff) begin
            res1 = `SRE_RES_TRAP_EL2; // R20
        end else if (acc_el != `SRE_EL3 && HAVE_EL3 != 0 && !lvl3_iface_en) begin
            res1 = `SRE_RES_TRAP_EL3;
        end
    end

    reg [2:0] res2;
    always @* begin
        res2 = `SRE_RES_OK;
        if (acc_el == `SRE_EL0 || acc_el == `SRE_EL1) begin
            res2 = `SRE_RES_UNDEF;
        end else if (acc_el == `SRE_EL2 && HAVE_EL3 != 0 && !lvl3_iface_en) begin
            res2 = `SRE_RES_TRAP_EL3;
        end
    end

    wire wr1 = hit1 && acc_write && res1 == `SRE_RES_OK;
    wire wr2 = hit2 && acc_write && res2 == `SRE_RES_OK && HAVE_EL2 != 0;

    // ============================================================
    // Interface-enable cells of level 1
    wire s_rd;
    wire ns_rd;
    sre_cell #(.FIXED_ONE(EFF_FIX_S || RAO_ALL)) u_cell_s (
        .clk       (clk),
        .rst       (rst),
        .gate_open (gate_s),
        .wr_en     (wr1 && sel_secure),
        .wr_bit    (acc_wdata[`SRE_BIT_IFACE_EN]),
        .rd_bit    (s_rd)
    ); // R15
    sre_cell #(.FIXED_ONE(EFF_FIX_NS || RAO_ALL)) u_cell_ns (
        .clk       (clk),
        .rst       (rst),
        .gate_open (gate_ns),
        .wr_en     (wr1 && !sel_secure),
        .wr_bit    (acc_wdata[`SRE_BIT_IFACE_EN]),
        .rd_bit    (ns_rd)
    ); // R14
    wire iface1_rd = sel_secure ? s_rd : ns_rd; // R11

    // ============================================================
    // Bypass-disable view shared by both registers
    // Own storage exists only without level 3; otherwise the level-3 bits
    // are the one copy and this block forwards level-2 writes, and level-1 writes only when level 2 is absent, to them while security-disable is one.
    wire byp_rw1 = (HAVE_EL3 != 0) && distributor_security_disable && (HAVE_EL2 == 0); // R5
    wire byp_rw2 = (HAVE_EL3 != 0) && distributor_security_disable; // R22
    wire own_byp1_wr = wr1 && (HAVE_EL3 == 0) && (HAVE_EL2 == 0);
    wire own_byp2_wr = wr2 && (HAVE_EL3 == 0);
    wire irq_own;
    wire fiq_own;
    sre_bypass #(.HAS_BYPASS(HAS_IRQ_BYP)) u_irq (
        .clk    (clk),
        .rst    (rst),
        .wr_en  (own_byp1_wr || own_byp2_wr),
        .wr_bit (acc_wdata[`SRE_BIT_IRQ_BYP_DIS]),
        .rd_bit (irq_own)
    ); // R2 R8
    sre_bypass #(.HAS_BYPASS(HAS_FIQ_BYP)) u_fiq (
        .clk    (clk),
        .rst    (rst),
        .wr_en  (own_byp1_wr || own_byp2_wr),
        .wr_bit (acc_wdata[`SRE_BIT_FIQ_BYP_DIS]),
        .rd_bit (fiq_own)
    ); // R3 R8
    // R4 R6 R7: without level 3 both registers read the same store.
    wire irq_view = (HAVE_EL3 != 0) ? (lvl3_irq_bypass_disable | (HAS_IRQ_BYP == 0)) : irq_own;
    wire fiq_view = (HAVE_EL3 != 0) ? (lvl3_fiq_bypass_disable | (HAS_FIQ_BYP == 0)) : fiq_own;

    // ============================================================
    // Level-2 storage updates
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            iface2_q  <= 1'b0; // R9
            trap_en_q <= 1'b0;
        end else if (wr2 && lvl3_gate) begin
            iface2_q  <= acc_wdata[`SRE_BIT_IFACE_EN];
            trap_en_q <= acc_wdata[`SRE_BIT_TRAP_EN];
        end
    end

    // ============================================================
    // Next answer and read words
    // Refused or missed accesses keep the data word at zero, so a trap never
    // leaks the state of a copy that the caller may not see.
    reg        lvl3_wr_d;
    reg  [2:0] result_d;
    reg  [5:0] syndrome_d;
    reg  [3:0] rd1_low;
    reg  [3:0] rd2_low;
    reg  [3:0] rdata_low_d;
    always @* begin
        rd1_low = {1'b0, irq_view, fiq_view, iface1_rd};
        rd2_low = 4'h0;
        if (HAVE_EL2 != 0) begin
            rd2_low = {trap_en_q, irq_view, fiq_view, iface2_rd};
        end
    end

    always @* begin
        lvl3_wr_d   = (wr1 && byp_rw1) || (wr2 && byp_rw2); // R5 R22
        result_d    = acc_valid ? `SRE_RES_NOHIT : `SRE_RES_OK;
        syndrome_d  = 6'h00;
        rdata_low_d = 4'h0;
        if (hit1) begin
            result_d = res1;
            if (is_trap(res1)) begin
                syndrome_d = `SRE_SYNDROME_CLASS; // R16
            end
            if (!acc_write && res1 == `SRE_RES_OK) begin
                rdata_low_d = rd1_low;
            end
        end else if (hit2) begin
            result_d = res2;
            if (is_trap(res2)) begin
                syndrome_d = `SRE_SYNDROME_CLASS;
            end
            if (!acc_write && res2 == `SRE_RES_OK) begin
                rdata_low_d = rd2_low;
            end
        end
    end

    // ============================================================
    // Answer and level-3 write-through
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_done               <= 1'b0;
            acc_result             <= `SRE_RES_OK;
            acc_syndrome           <= 6'h00;
            acc_rdata              <= 64'h0000000000000000;
            lvl3_bypass_wr         <= 1'b0;
            lvl3_bypass_wdata      <= 2'h0;
            iface_en_current       <= 1'b0;
            other_sysreg_trap_lvl1 <= 1'b1;
            irq_bypass_disable     <= 1'b0;
            fiq_bypass_disable     <= 1'b0;
        end else begin
            acc_done               <= acc_valid;
            acc_result             <= result_d;
            acc_syndrome           <= syndrome_d;
            acc_rdata              <= {60'h000000000000000, rdata_low_d}; // R1 R19
            lvl3_bypass_wr         <= lvl3_wr_d;
            lvl3_bypass_wdata      <= {acc_wdata[`SRE_BIT_IRQ_BYP_DIS], acc_wdata[`SRE_BIT_FIQ_BYP_DIS]};
            iface_en_current       <= iface1_rd;
            other_sysreg_trap_lvl1 <= ~iface1_rd; // R10
            irq_bypass_disable     <= irq_view;
            fiq_bypass_disable     <= fiq_view;
        end
    end
endmodule

`default_nettype wire

// file: dv/sre_enable_bank_asserts.sv
/* Checker for the enable bank's access answers and status outputs.
   Assumes it is bound to sre_enable_bank with default parameters. */
`timescale 1ns/1ps
`default_nettype none
`include "sre_defs.vh"

// ============================================================
// Assertions
module sre_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [1:0]  acc_el,
    input wire logic [63:0] acc_wdata,
    input wire logic        distributor_security_disable,
    input wire logic        lvl3_irq_bypass_disable,
    input wire logic        lvl3_bypass_wr,
    input wire logic [1:0]  lvl3_bypass_wdata,
    input wire logic        acc_done,
    input wire logic [2:0]  acc_result,
    input wire logic [5:0]  acc_syndrome,
    input wire logic [63:0] acc_rdata,
    input wire logic        iface_en_current,
    input wire logic        other_sysreg_trap_lvl1,
    input wire logic        irq_bypass_disable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_ANSWER: assert property (acc_valid |=> acc_done)
        else $error("no answer one cycle after an access");
    AST_NO_SPURIOUS: assert property (!acc_valid |=> !acc_done)
        else $error("answer without an access");
    AST_UNDEF: assert property (acc_valid && acc_el == `SRE_EL0 |=> acc_result == `SRE_RES_UNDEF)
        else $error("level 0 access not undefined");
    AST_SYNDROME: assert property (acc_done && (acc_result == `SRE_RES_TRAP_EL2 || acc_result == `SRE_RES_TRAP_EL3)
        |-> acc_syndrome == `SRE_SYNDROME_CLASS)
        else $error("wrong syndrome on trap");
    AST_TRAP_NODATA: assert property (acc_done && acc_result != `SRE_RES_OK |-> acc_rdata == 64'h0 && !lvl3_bypass_wr)
        else $error("refused access gave data or a write");
    AST_RES0: assert property (acc_done |-> acc_rdata[63:4] == 60'h0)
        else $error("reserved bits not zero");
    AST_TRAP_OTHER: assert property (other_sysreg_trap_lvl1 == !iface_en_current)
        else $error("other register trap not inverse of enable");
    AST_WRTHRU: assert property (lvl3_bypass_wr |-> $past(acc_valid && acc_write)
        && lvl3_bypass_wdata == $past(acc_wdata[2:1]))
        else $error("bad write-through to level 3");
    AST_RO_ALIAS: assert property (acc_valid && !distributor_security_disable |=> !lvl3_bypass_wr)
        else $error("write-through while alias is read-only");
    AST_IRQ_MIRROR: assert property (!$past(rst) |-> irq_bypass_disable == $past(lvl3_irq_bypass_disable))
        else $error("irq bypass disable does not follow level 3");

    cover property (acc_done && acc_result == `SRE_RES_TRAP_EL2);
    cover property (lvl3_bypass_wr);
    cover property (acc_done && acc_result == `SRE_RES_OK && acc_rdata[0]);
endmodule

bind sre_enable_bank sre_chk u_chk (.clk, .rst, .acc_valid, .acc_write, .acc_el, .acc_wdata,
    .distributor_security_disable, .lvl3_irq_bypass_disable, .lvl3_bypass_wr, .lvl3_bypass_wdata,
    .acc_done, .acc_result, .acc_syndrome, .acc_rdata, .iface_en_current, .other_sysreg_trap_lvl1,
    .irq_bypass_disable);
`default_nettype wire

// file: dv/sre_enable_bank_tb.sv
/* Self-checking bench for the enable bank.
   Assumes default parameters: levels 2 and 3 present, both bypasses present. */
`timescale 1ns/1ps
`default_nettype none
`include "sre_defs.vh"

// ============================================================
// Bench
module sre_enable_bank_tb;
    localparam logic [6:0] L1 = {3'h0, 4'hC};
    localparam logic [6:0] L2 = {3'h4, 4'h9};
    localparam logic [6:0] BAD = {3'h7, 4'hC};
    logic clk = 1'b0, rst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
    logic [1:0] acc_el = 2'h0;
    logic [2:0] acc_op1 = 3'h0, acc_result;
    logic [3:0] acc_crm = 4'h0;
    logic [63:0] acc_wdata = 64'h0, acc_rdata;
    logic sss = 1'b0, ds = 1'b0, l3en = 1'b1, el2en = 1'b1, irq3, fiq3, l3wr, done, ien, otrap, irqd, fiqd;
    logic [1:0] l3wd;
    logic [5:0] syn;
    int err_count = 0, comparisons = 0, cycles = 0;

    always #12.5 clk = ~clk;

    sre_enable_bank dut (.clk(clk), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write), .acc_el(acc_el),
        .acc_op0(`SRE_ENC_OP0), .acc_op1(acc_op1), .acc_crn(`SRE_ENC_CRN), .acc_crm(acc_crm),
        .acc_op2(`SRE_ENC_OP2), .acc_wdata(acc_wdata), .secure_state_select(sss),
        .distributor_security_disable(ds), .el2_enabled(el2en), .lvl3_iface_en(l3en),
        .lvl3_irq_bypass_disable(irq3), .lvl3_fiq_bypass_disable(fiq3), .lvl3_bypass_wr(l3wr),
        .lvl3_bypass_wdata(l3wd), .acc_done(done), .acc_result(acc_result), .acc_syndrome(syn),
        .acc_rdata(acc_rdata), .iface_en_current(ien), .other_sysreg_trap_lvl1(otrap),
        .irq_bypass_disable(irqd), .fiq_bypass_disable(fiqd));
    sre_lvl3_model u_l3 (.clk(clk), .rst(rst), .wr(l3wr), .wdata(l3wd), .irq_dis(irq3), .fiq_dis(fiq3));

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access, answer sampled mid-cycle while it stands.
    task automatic acc(input logic [1:0] el, input logic wr, input logic [6:0] enc,
                       input logic [63:0] wd, input logic [2:0] res, input logic [63:0] rd);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = wr;
        acc_el = el;
        {acc_op1, acc_crm} = enc;
        acc_wdata = wd;
        @(negedge clk);
        acc_valid = 1'b0;
        check({done, acc_result}, {1'b1, res});
        check(acc_rdata, rd);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL2, 1'b0, L2, 64'h0, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL0, 1'b0, L1, 64'h0, `SRE_RES_UNDEF, 64'h0);
        acc(`SRE_EL1, 1'b0, BAD, 64'h0, `SRE_RES_NOHIT, 64'h0);
        $display("test reset and decode done");
        acc(`SRE_EL1, 1'b1, L1, 64'h7, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h1);
        @(negedge clk);
        check(otrap, 1'b0);
        check(ien, 1'b1);
        sss = 1'b1;
        acc(`SRE_EL1, 1'b1, L1, 64'h1, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h0);
        @(negedge clk);
        check(otrap, 1'b1);
        check(ien, 1'b0);
        $display("test copy enables done");
        ds = 1'b1;
        acc(`SRE_EL2, 1'b1, L2, 64'h7, `SRE_RES_OK, 64'h0);
        // The level-3 bits sit one register beyond the write-through strobe.
        @(negedge clk);
        acc(`SRE_EL2, 1'b0, L2, 64'h0, `SRE_RES_OK, 64'h7);
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_TRAP_EL2, 64'h0);
        check(syn, `SRE_SYNDROME_CLASS);
        el2en = 1'b0;
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h6);
        check(syn, 6'h00);
        el2en = 1'b1;
        acc(`SRE_EL2, 1'b1, L2, 64'hF, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL1, 1'b1, L1, 64'h1, `SRE_RES_OK, 64'h0);
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h7);
        @(negedge clk);
        check({irqd, fiqd}, 2'h3);
        $display("test bypass and trap done");
        sss = 1'b0;
        l3en = 1'b0;
        acc(`SRE_EL3, 1'b0, L1, 64'h0, `SRE_RES_OK, 64'h6);
        acc(`SRE_EL1, 1'b0, L1, 64'h0, `SRE_RES_TRAP_EL3, 64'h0);
        $display("test level 3 gate done");
        close_out();
    end
endmodule
`default_nettype wire

// file: dv/sre_lvl3_model.sv
/* Model of the level-3 bypass-disable bits beside the bank.
   Assumes the bank's write-through strobe and data are registered. */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Level-3 bits
module sre_lvl3_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr,
    input  wire logic [1:0] wdata,
    output var  logic       irq_dis,
    output var  logic       fiq_dis
);
    // Only the write-through changes them, so they stay read-only otherwise.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_dis <= 1'b0;
            fiq_dis <= 1'b0;
        end else if (wr) begin
            irq_dis <= wdata[1];
            fiq_dis <= wdata[0];
        end
    end
endmodule
`default_nettype wire
